/* verilog/tsu_top.sv */
/*
  Task switch unit: sequences a hardware task switch, holds the task
  pointer and fault address system registers, forms linear addresses.
  Assumes decode logic pulses SWITCH_REQ with the descriptor already
  fetched, and that paging and protection checks live elsewhere.
*/
`timescale 1ns/1ns
// Summary of operation
// - On a page fault, capture the faulting linear address in the fault address register.
// - Only privileged instructions may read or write system registers.
// - Task pointer register holds selector and descriptor of the running task's record.
// - On a task jump, save registers first, then load the task pointer register.
// - After the task pointer update, restore registers from the new record.
// - When switching completes, fetch resumes at the restored instruction pointer.
// - The saved instruction pointer points past the jump that suspended the task.
// - Only the lower, register-holding part of a record is ever written.
// - A full switch targets about 17 microseconds; longer switches are flagged.
// - Linear address is segment base plus offset, optionally passed on to paging.
module tsu_top (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic SWITCH_REQ,
  input wire logic [tsu_pkg::SEL_W-1:0] SWITCH_SEL,
  input wire logic [tsu_pkg::ADDR_W-1:0] DESC_BASE,
  input wire logic [tsu_pkg::ADDR_W-1:0] DESC_LIMIT,
  input wire logic [tsu_pkg::ADDR_W-1:0] NEXT_IP,
  output logic SWITCH_BUSY,
  output logic SWITCH_SLOW,
  output logic INT_HOLD,
  output logic FETCH_LOAD,
  output logic [tsu_pkg::ADDR_W-1:0] FETCH_IP,
  output logic [tsu_pkg::SEL_W-1:0] TP_SEL,
  output logic [tsu_pkg::ADDR_W-1:0] TP_BASE,
  output logic [tsu_pkg::ADDR_W-1:0] TP_LIMIT,
  input wire logic PAGE_FAULT,
  input wire logic [tsu_pkg::ADDR_W-1:0] FAULT_LINADDR,
  input wire logic PRIV,
  input wire logic SYS_WE,
  input wire logic SYS_RE,
  input wire logic SYS_SEL,
  input wire logic [tsu_pkg::ADDR_W-1:0] SYS_WDATA,
  output logic [tsu_pkg::ADDR_W-1:0] SYS_RDATA,
  output logic SYS_DENIED,
  output logic [tsu_pkg::ADDR_W-1:0] FAULT_ADDR,
  input wire logic ADDR_VALID,
  input wire logic [tsu_pkg::ADDR_W-1:0] SEG_BASE,
  input wire logic [tsu_pkg::ADDR_W-1:0] SEG_OFFSET,
  input wire logic PAGING_EN,
  output logic LIN_VALID,
  output logic LIN_PAGED,
  output logic [tsu_pkg::ADDR_W-1:0] LIN_ADDR,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [tsu_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [tsu_pkg::ADDR_W-1:0] MEM_WDATA,
  input wire logic [tsu_pkg::ADDR_W-1:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic [tsu_pkg::IDX_W-1:0] REG_IDX,
  output logic REG_WE,
  output logic [tsu_pkg::ADDR_W-1:0] REG_WDATA,
  input wire logic [tsu_pkg::ADDR_W-1:0] REG_RDATA
);
  tsu_pkg::tsu_state_t state_ff, nxt_state;
  logic start_ff, save_dir_ff, fetch_load_ff, slow_ff, hold_ff, denied_ff;
  logic lin_valid_ff, lin_paged_ff;
  logic [tsu_pkg::SEL_W-1:0] tp_sel_ff, new_sel_ff;
  logic [tsu_pkg::ADDR_W-1:0] tp_base_ff, tp_limit_ff, new_base_ff, new_limit_ff;
  logic [tsu_pkg::ADDR_W-1:0] ret_ip_ff, fetch_ip_ff, fault_ff, rdata_ff, lin_ff;
  logic [tsu_pkg::CNT_W-1:0] cnt_ff;

  tsu_xfer_if xf ();

  tsu_mover u_mover (
    .CLOCK(CLOCK),
    .ARST_N(ARST_N),
    .xf(xf.mover),
    .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA),
    .MEM_ACK(MEM_ACK),
    .REG_IDX(REG_IDX),
    .REG_WE(REG_WE),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire idle = (state_ff == tsu_pkg::TSU_IDLE);
  wire take_switch = idle && SWITCH_REQ;
  wire sys_ok = PRIV && idle;
  wire sys_bad = (SYS_WE || SYS_RE) && !PRIV;
  wire wr_fault = SYS_WE && sys_ok && (SYS_SEL == tsu_pkg::SYS_FAULT_ADDR);
  wire wr_tp = SYS_WE && sys_ok && (SYS_SEL == tsu_pkg::SYS_TASK_PTR);
  wire [tsu_pkg::ADDR_W-1:0] sys_view = (SYS_SEL == tsu_pkg::SYS_TASK_PTR) ?
    {{(tsu_pkg::ADDR_W-tsu_pkg::SEL_W){1'b0}}, tp_sel_ff} : fault_ff;
  wire [tsu_pkg::ADDR_W-1:0] lin_sum = SEG_BASE + SEG_OFFSET;
  wire over_budget = (cnt_ff > tsu_pkg::SWITCH_CYCLES);

  always_comb begin
    case (state_ff)
      tsu_pkg::TSU_IDLE: nxt_state = SWITCH_REQ ? tsu_pkg::TSU_SAVE : tsu_pkg::TSU_IDLE;
      // The pointer register changes only after the old set is stored
      tsu_pkg::TSU_SAVE: nxt_state = xf.done ? tsu_pkg::TSU_LOAD_TP : tsu_pkg::TSU_SAVE;
      tsu_pkg::TSU_LOAD_TP: nxt_state = tsu_pkg::TSU_RESTORE;
      tsu_pkg::TSU_RESTORE: nxt_state = xf.done ? tsu_pkg::TSU_RESUME : tsu_pkg::TSU_RESTORE;
      tsu_pkg::TSU_RESUME: nxt_state = tsu_pkg::TSU_IDLE;
      default: nxt_state = tsu_pkg::TSU_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Switch sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= tsu_pkg::TSU_IDLE;
      start_ff <= 1'b0;
      save_dir_ff <= 1'b0;
      fetch_load_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= take_switch || (state_ff == tsu_pkg::TSU_LOAD_TP);
      save_dir_ff <= take_switch;
      fetch_load_ff <= (state_ff == tsu_pkg::TSU_RESTORE) && xf.done;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      new_sel_ff <= tsu_pkg::SEL_ZERO;
      new_base_ff <= tsu_pkg::WORD_ZERO;
      new_limit_ff <= tsu_pkg::WORD_ZERO;
      ret_ip_ff <= tsu_pkg::WORD_ZERO;
      fetch_ip_ff <= tsu_pkg::WORD_ZERO;
    end else begin
      if (take_switch) begin
        new_sel_ff <= SWITCH_SEL;
        new_base_ff <= DESC_BASE;
        new_limit_ff <= DESC_LIMIT;
        ret_ip_ff <= NEXT_IP;
      end
      if ((state_ff == tsu_pkg::TSU_RESTORE) && xf.done) begin
        fetch_ip_ff <= xf.ip_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Task pointer register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tp_sel_ff <= tsu_pkg::SEL_ZERO;
      tp_base_ff <= tsu_pkg::WORD_ZERO;
      tp_limit_ff <= tsu_pkg::WORD_ZERO;
    end else if (state_ff == tsu_pkg::TSU_LOAD_TP) begin
      tp_sel_ff <= new_sel_ff;
      tp_base_ff <= new_base_ff;
      tp_limit_ff <= new_limit_ff;
    end else if (wr_tp) begin
      // Privileged load takes the selector and the descriptor presented now
      tp_sel_ff <= SYS_WDATA[tsu_pkg::SEL_W-1:0];
      tp_base_ff <= DESC_BASE;
      tp_limit_ff <= DESC_LIMIT;
    end
  end

  // ----------------------------------------------------------------
  // Fault address and privileged access
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault_ff <= tsu_pkg::WORD_ZERO;
      rdata_ff <= tsu_pkg::WORD_ZERO;
      denied_ff <= 1'b0;
    end else begin
      // A fault in the same cycle as a software write wins
      if (PAGE_FAULT) begin
        fault_ff <= FAULT_LINADDR;
      end else if (wr_fault) begin
        fault_ff <= SYS_WDATA;
      end
      if (SYS_RE && sys_ok) begin
        rdata_ff <= sys_view;
      end
      denied_ff <= sys_bad;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt hold and switch budget
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_ff <= 1'b0;
      cnt_ff <= tsu_pkg::CNT_ZERO;
      slow_ff <= 1'b0;
    end else begin
      // Raised with the request so no interrupt slips in before the save
      hold_ff <= (nxt_state != tsu_pkg::TSU_IDLE);
      if (take_switch) begin
        cnt_ff <= tsu_pkg::CNT_ONE;
      end else if (!idle && !over_budget) begin
        cnt_ff <= cnt_ff + tsu_pkg::CNT_ONE;
      end
      if (take_switch) begin
        slow_ff <= 1'b0;
      end else if (state_ff == tsu_pkg::TSU_RESUME) begin
        slow_ff <= over_budget;
      end
    end
  end

  // ----------------------------------------------------------------
  // Linear address path
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      lin_ff <= tsu_pkg::WORD_ZERO;
      lin_valid_ff <= 1'b0;
      lin_paged_ff <= 1'b0;
    end else begin
      lin_valid_ff <= ADDR_VALID;
      if (ADDR_VALID) begin
        lin_ff <= lin_sum;
        lin_paged_ff <= PAGING_EN;
      end
    end
  end

  assign xf.start = start_ff;
  assign xf.dir_save = save_dir_ff;
  // Save walk sees the old record, restore walk the one just loaded in LOAD_TP
  assign xf.base = tp_base_ff;
  assign xf.save_ip = ret_ip_ff;
  assign SWITCH_BUSY = !idle;
  assign SWITCH_SLOW = slow_ff;
  assign INT_HOLD = hold_ff || SWITCH_REQ;
  assign FETCH_LOAD = fetch_load_ff;
  assign FETCH_IP = fetch_ip_ff;
  assign TP_SEL = tp_sel_ff;
  assign TP_BASE = tp_base_ff;
  assign TP_LIMIT = tp_limit_ff;
  assign SYS_RDATA = rdata_ff;
  assign SYS_DENIED = denied_ff;
  assign FAULT_ADDR = fault_ff;
  assign LIN_ADDR = lin_ff;
  assign LIN_VALID = lin_valid_ff;
  assign LIN_PAGED = lin_paged_ff;
endmodule

/* verilog/tsu_pkg.sv */
/*
  Shared constants and types for the task switch unit.
  Assumes a single 20 MHz core clock and 32-bit word memory.
*/
package tsu_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int SEL_W = 16;
  localparam int IDX_W = 4;
  // Index of the last word in the processor-maintained lower part of a task-state record
  localparam logic [IDX_W-1:0] REC_LAST_IDX = 4'hF;
  // Word holding the instruction pointer inside the record
  localparam logic [IDX_W-1:0] REC_IP_IDX = 4'h0;
  localparam logic [1:0] WORD_SHIFT_ZERO = 2'h0;

  // ----------------------------------------------------------------
  // System register selectors for privileged access
  // ----------------------------------------------------------------
  localparam logic SYS_FAULT_ADDR = 1'h0;
  localparam logic SYS_TASK_PTR = 1'h1;

  // ----------------------------------------------------------------
  // Timing: switch budget
  // ----------------------------------------------------------------
  localparam int SWITCH_TIME_NS = 17000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W = 10;
  // Longest time, so round down
  localparam logic [CNT_W-1:0] SWITCH_CYCLES = CNT_W'(SWITCH_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] WORD_ZERO = 32'h00000000;
  localparam logic [SEL_W-1:0] SEL_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TSU_IDLE = 3'h0,
    TSU_SAVE = 3'h1,
    TSU_LOAD_TP = 3'h3,
    TSU_RESTORE = 3'h2,
    TSU_RESUME = 3'h6
  } tsu_state_t;

  typedef enum logic [1:0] {
    TSU_MV_IDLE = 2'h0,
    TSU_MV_ISSUE = 2'h1,
    TSU_MV_WAIT = 2'h3,
    TSU_MV_DONE = 2'h2
  } tsu_mv_state_t;
endpackage

/* verilog/tsu_xfer_if.sv */
/*
  Command carrier between the switch sequencer and the record mover.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface tsu_xfer_if;
  logic start;
  logic dir_save;
  logic [tsu_pkg::ADDR_W-1:0] base;
  logic [tsu_pkg::ADDR_W-1:0] save_ip;
  logic done;
  logic [tsu_pkg::ADDR_W-1:0] ip_word;

  modport seq (output start, output dir_save, output base, output save_ip,
               input done, input ip_word);
  modport mover (input start, input dir_save, input base, input save_ip,
                 output done, output ip_word);
endinterface

/* verilog/tsu_mover.sv */
/*
  Record mover: walks the lower part of a task-state record, one word
  per memory handshake, saving core registers or restoring them.
  Assumes memory holds MEM_ACK for one cycle per accepted request and the
  core register file reads combinationally by index.
*/
`timescale 1ns/1ns
module tsu_mover (
  input wire logic CLOCK,
  input wire logic ARST_N,
  tsu_xfer_if.mover xf,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [tsu_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [tsu_pkg::ADDR_W-1:0] MEM_WDATA,
  input wire logic [tsu_pkg::ADDR_W-1:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic [tsu_pkg::IDX_W-1:0] REG_IDX,
  output logic REG_WE,
  output logic [tsu_pkg::ADDR_W-1:0] REG_WDATA,
  input wire logic [tsu_pkg::ADDR_W-1:0] REG_RDATA
);
  tsu_pkg::tsu_mv_state_t state_ff, nxt_state;
  logic [tsu_pkg::IDX_W-1:0] idx_ff;
  logic save_ff, req_ff, reg_we_ff;
  logic [tsu_pkg::ADDR_W-1:0] base_ff, addr_ff, wdata_ff, reg_wdata_ff, ip_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_ip_word = (idx_ff == tsu_pkg::REC_IP_IDX);
  wire is_last = (idx_ff == tsu_pkg::REC_LAST_IDX);
  wire acked = (state_ff == tsu_pkg::TSU_MV_WAIT) && MEM_ACK;
  // Offsets never pass the last lower word, so the OS part stays untouched
  wire [tsu_pkg::ADDR_W-1:0] word_addr =
    base_ff + {{(tsu_pkg::ADDR_W-tsu_pkg::IDX_W-2){1'b0}}, idx_ff, tsu_pkg::WORD_SHIFT_ZERO};
  // Saved IP is the one past the switching jump, not the live register
  wire [tsu_pkg::ADDR_W-1:0] save_word = is_ip_word ? xf.save_ip : REG_RDATA;

  always_comb begin
    case (state_ff)
      tsu_pkg::TSU_MV_IDLE: nxt_state = xf.start ? tsu_pkg::TSU_MV_ISSUE : tsu_pkg::TSU_MV_IDLE;
      tsu_pkg::TSU_MV_ISSUE: nxt_state = tsu_pkg::TSU_MV_WAIT;
      tsu_pkg::TSU_MV_WAIT: begin
        if (MEM_ACK) begin
          nxt_state = is_last ? tsu_pkg::TSU_MV_DONE : tsu_pkg::TSU_MV_ISSUE;
        end else begin
          nxt_state = tsu_pkg::TSU_MV_WAIT;
        end
      end
      tsu_pkg::TSU_MV_DONE: nxt_state = tsu_pkg::TSU_MV_IDLE;
      default: nxt_state = tsu_pkg::TSU_MV_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= tsu_pkg::TSU_MV_IDLE;
      idx_ff <= tsu_pkg::REC_IP_IDX;
      save_ff <= 1'b0;
      base_ff <= tsu_pkg::WORD_ZERO;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == tsu_pkg::TSU_MV_IDLE && xf.start) begin
        idx_ff <= tsu_pkg::REC_IP_IDX;
        save_ff <= xf.dir_save;
        base_ff <= xf.base;
      end else if (acked) begin
        idx_ff <= idx_ff + {{(tsu_pkg::IDX_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_ff <= 1'b0;
      addr_ff <= tsu_pkg::WORD_ZERO;
      wdata_ff <= tsu_pkg::WORD_ZERO;
    end else begin
      req_ff <= (nxt_state == tsu_pkg::TSU_MV_ISSUE) || (nxt_state == tsu_pkg::TSU_MV_WAIT);
      if (state_ff == tsu_pkg::TSU_MV_ISSUE) begin
        addr_ff <= word_addr;
        wdata_ff <= save_word;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      reg_we_ff <= 1'b0;
      reg_wdata_ff <= tsu_pkg::WORD_ZERO;
      ip_ff <= tsu_pkg::WORD_ZERO;
    end else begin
      reg_we_ff <= acked && !save_ff;
      if (acked && !save_ff) begin
        reg_wdata_ff <= MEM_RDATA;
        if (is_ip_word) begin
          ip_ff <= MEM_RDATA;
        end
      end
    end
  end

  assign MEM_REQ = req_ff && (state_ff == tsu_pkg::TSU_MV_WAIT);
  assign MEM_WE = save_ff;
  assign MEM_ADDR = addr_ff;
  assign MEM_WDATA = wdata_ff;
  assign REG_IDX = idx_ff;
  assign REG_WE = reg_we_ff;
  assign REG_WDATA = reg_wdata_ff;
  assign xf.done = (state_ff == tsu_pkg::TSU_MV_DONE);
  assign xf.ip_word = ip_ff;
endmodule

/* verification/tsu_properties.sv */
/*
  Port-level checker for the task switch unit top.
  Assumes it is bound to tsu_top; one clock, reset asynchronous and low active.
*/
`timescale 1ns/1ns
module tsu_properties (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic SWITCH_REQ,
  input wire logic [15:0] SWITCH_SEL,
  input wire logic [31:0] DESC_BASE,
  input wire logic [31:0] NEXT_IP,
  input wire logic SWITCH_BUSY,
  input wire logic INT_HOLD,
  input wire logic FETCH_LOAD,
  input wire logic [15:0] TP_SEL,
  input wire logic [31:0] TP_BASE,
  input wire logic PAGE_FAULT,
  input wire logic [31:0] FAULT_LINADDR,
  input wire logic [31:0] FAULT_ADDR,
  input wire logic PRIV,
  input wire logic SYS_WE,
  input wire logic SYS_RE,
  input wire logic SYS_DENIED,
  input wire logic ADDR_VALID,
  input wire logic [31:0] SEG_BASE,
  input wire logic [31:0] SEG_OFFSET,
  input wire logic PAGING_EN,
  input wire logic LIN_VALID,
  input wire logic LIN_PAGED,
  input wire logic [31:0] LIN_ADDR,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA
);
  // ----
  // Snapshot of the accepted request
  // ----
  logic [15:0] sel_ff;
  logic [31:0] base_ff;
  logic [31:0] ip_ff;
  wire logic take_req = SWITCH_REQ && !SWITCH_BUSY;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_ff <= 16'h0000;
      base_ff <= 32'h0;
      ip_ff <= 32'h0;
    end else if (take_req) begin
      sel_ff <= SWITCH_SEL;
      base_ff <= DESC_BASE;
      ip_ff <= NEXT_IP;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  a_fault_capture: assert property (PAGE_FAULT |=> FAULT_ADDR == $past(FAULT_LINADDR))
    else $error("fault address not captured");
  a_unpriv_denied: assert property ((SYS_WE || SYS_RE) && !PRIV && !SWITCH_BUSY |=> SYS_DENIED)
    else $error("unprivileged access not denied");
  a_unpriv_no_write: assert property (SYS_WE && !PRIV && !SWITCH_BUSY && !SWITCH_REQ
    && !PAGE_FAULT |=> $stable(TP_SEL) && $stable(FAULT_ADDR))
    else $error("unprivileged write changed a system register");
  a_tp_on_resume: assert property (FETCH_LOAD |-> TP_SEL == sel_ff && TP_BASE == base_ff)
    else $error("task pointer does not hold the new record");
  a_save_old_rec: assert property (MEM_REQ && MEM_WE |-> (MEM_ADDR - TP_BASE) < 32'h40
    && MEM_ADDR[1:0] == 2'h0)
    else $error("save outside the lower part of the current record");
  a_save_ip_first: assert property (MEM_REQ && MEM_WE && MEM_ADDR == TP_BASE
    |-> MEM_WDATA == ip_ff)
    else $error("saved instruction pointer is not the one after the jump");
  a_restore_new: assert property (MEM_REQ && !MEM_WE |-> TP_BASE == base_ff
    && (MEM_ADDR - base_ff) < 32'h40)
    else $error("restore not from the new record");
  a_resume_ends: assert property (FETCH_LOAD |=> !SWITCH_BUSY && !FETCH_LOAD)
    else $error("switch does not end after fetch resume");
  a_int_held: assert property (SWITCH_REQ || SWITCH_BUSY |-> INT_HOLD)
    else $error("interrupts open during a switch");
  a_lin_addr: assert property (ADDR_VALID |=> LIN_VALID && LIN_PAGED == $past(PAGING_EN)
    && LIN_ADDR == $past(SEG_BASE) + $past(SEG_OFFSET))
    else $error("linear address wrong");
endmodule

/* verification/tb_top.sv */
/*
  Self-checking bench for the task switch unit, with memory and core registers.
  Assumes the unit's package, interface and modules are compiled first.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  logic CLOCK = 1'b0, ARST_N = 1'b0, SWITCH_REQ = 1'b0, PAGE_FAULT = 1'b0, PRIV = 1'b0;
  logic SYS_WE = 1'b0, SYS_RE = 1'b0, SYS_SEL = 1'b0, ADDR_VALID = 1'b0, PAGING_EN = 1'b0;
  logic MEM_ACK = 1'b0;
  logic [15:0] SWITCH_SEL = 16'h0000;
  logic [31:0] DESC_BASE = 32'h0, DESC_LIMIT = 32'h0, NEXT_IP = 32'h0, FAULT_LINADDR = 32'h0;
  logic [31:0] SYS_WDATA = 32'h0, SEG_BASE = 32'h0, SEG_OFFSET = 32'h0, MEM_RDATA = 32'h0;
  logic SWITCH_BUSY, SWITCH_SLOW, INT_HOLD, FETCH_LOAD, SYS_DENIED, LIN_VALID, LIN_PAGED;
  logic MEM_REQ, MEM_WE, REG_WE;
  logic [15:0] TP_SEL;
  logic [31:0] FETCH_IP, TP_BASE, TP_LIMIT, SYS_RDATA, FAULT_ADDR, LIN_ADDR, MEM_ADDR;
  logic [31:0] MEM_WDATA, REG_WDATA, REG_RDATA;
  logic [3:0] REG_IDX, ack_idx;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rf [16];
  int ack_wait = 0, wait_cnt = 0, cycles = 0, miscompares = 0, comparisons = 0;

  tsu_top uut (.*);

  initial forever #25 CLOCK = ~CLOCK;

  // ----
  // Memory and core register file
  // ----
  // Released read data toggles so a stale word is never mistaken for an answer
  always @(posedge CLOCK) begin
    if (MEM_REQ && !MEM_ACK && wait_cnt >= ack_wait) begin
      MEM_ACK <= 1'b1;
      wait_cnt <= 0;
      MEM_RDATA <= MEM_WE ? ~MEM_RDATA : mem[MEM_ADDR];
      if (MEM_WE) mem[MEM_ADDR] = MEM_WDATA;
    end else begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
      if (MEM_REQ && !MEM_ACK) wait_cnt <= wait_cnt + 1;
    end
    if (MEM_ACK) ack_idx <= REG_IDX;
    if (REG_WE) rf[ack_idx] <= REG_WDATA;
  end
  assign REG_RDATA = rf[REG_IDX];

  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    for (int i = 0; i < 16; i++) rf[i] = 32'hC000_0000 + 32'(i);
    repeat (5) @(posedge CLOCK);
    #1;
    `CHK(TP_SEL, 16'h0000)
    `CHK(SWITCH_BUSY, 1'b0)
    // Released on the sixth edge, like every other input
    @(posedge CLOCK);
    ARST_N <= 1'b1;
  endtask

  task automatic t_switch(input logic [15:0] sel, input logic [31:0] base,
    input logic [31:0] old, input logic [31:0] ip, input int wt, input logic slow);
    logic [31:0] snap [16];
    snap = rf;
    for (int i = 0; i < 16; i++) mem[32'(base + 4 * i)] = 32'hA500_0000 + base + 32'(i);
    mem[base + 32'h40] = 32'h5A5A_5A5A;
    mem[old + 32'h40] = 32'h5A5A_5A5A;
    ack_wait = wt;
    @(posedge CLOCK);
    SWITCH_REQ <= 1'b1;
    SWITCH_SEL <= sel;
    DESC_BASE <= base;
    DESC_LIMIT <= base + 32'h67;
    NEXT_IP <= ip;
    @(posedge CLOCK);
    SWITCH_REQ <= 1'b0;
    repeat (5) @(posedge CLOCK);
    // A second jump while busy must be ignored
    SWITCH_REQ <= 1'b1;
    SWITCH_SEL <= ~sel;
    DESC_BASE <= 32'h0000_F000;
    @(posedge CLOCK);
    SWITCH_REQ <= 1'b0;
    #1;
    for (int n = 0; n < 2000 && FETCH_LOAD !== 1'b1; n++) begin
      @(posedge CLOCK);
      #1;
    end
    `CHK(FETCH_LOAD, 1'b1)
    `CHK(FETCH_IP, 32'hA500_0000 + base)
    `CHK(TP_SEL, sel)
    `CHK(TP_BASE, base)
    `CHK(TP_LIMIT, base + 32'h67)
    @(posedge CLOCK);
    #1;
    `CHK(SWITCH_BUSY, 1'b0)
    `CHK(SWITCH_SLOW, slow)
    for (int i = 0; i < 16; i++) begin
      `CHK(rf[i], 32'hA500_0000 + base + 32'(i))
      `CHK(mem[32'(old + 4 * i)], (i == 0) ? ip : snap[i])
    end
    `CHK(mem[base + 32'h40], 32'h5A5A_5A5A)
    `CHK(mem[old + 32'h40], 32'h5A5A_5A5A)
  endtask

  task automatic sys_acc(input logic p, input logic we, input logic sel, input logic [31:0] d);
    @(posedge CLOCK);
    PRIV <= p;
    SYS_WE <= we;
    SYS_RE <= !we;
    SYS_SEL <= sel;
    SYS_WDATA <= d;
    @(posedge CLOCK);
    SYS_WE <= 1'b0;
    SYS_RE <= 1'b0;
    #1;
  endtask

  task automatic t_sys(input logic [15:0] sel);
    sys_acc(1'b1, 1'b1, 1'b0, 32'h0000_1234);
    `CHK(FAULT_ADDR, 32'h0000_1234)
    sys_acc(1'b1, 1'b0, 1'b0, 32'h0);
    `CHK(SYS_RDATA, 32'h0000_1234)
    sys_acc(1'b0, 1'b1, 1'b0, 32'h0000_DEAD);
    `CHK(SYS_DENIED, 1'b1)
    `CHK(FAULT_ADDR, 32'h0000_1234)
    sys_acc(1'b0, 1'b1, 1'b1, 32'h0000_0077);
    `CHK(SYS_DENIED, 1'b1)
    `CHK(TP_SEL, sel)
    sys_acc(1'b0, 1'b0, 1'b1, 32'h0);
    `CHK(SYS_DENIED, 1'b1)
    sys_acc(1'b1, 1'b0, 1'b1, 32'h0);
    `CHK(SYS_RDATA, {16'h0000, sel})
    // Privileged pointer load takes the descriptor still presented by the last ignored jump
    sys_acc(1'b1, 1'b1, 1'b1, 32'hABCD_0048);
    `CHK(TP_SEL, 16'h0048)
    `CHK(TP_BASE, 32'h0000_F000)
  endtask

  task automatic t_fault;
    // Fault and a privileged write in the same cycle: the fault wins
    @(posedge CLOCK);
    PAGE_FAULT <= 1'b1;
    FAULT_LINADDR <= 32'h0040_3FFC;
    PRIV <= 1'b1;
    SYS_WE <= 1'b1;
    SYS_SEL <= 1'b0;
    SYS_WDATA <= 32'h0000_1111;
    @(posedge CLOCK);
    PAGE_FAULT <= 1'b0;
    SYS_WE <= 1'b0;
    #1;
    `CHK(FAULT_ADDR, 32'h0040_3FFC)
  endtask

  task automatic t_lin;
    for (int p = 0; p < 2; p++) begin
      @(posedge CLOCK);
      ADDR_VALID <= 1'b1;
      SEG_BASE <= 32'hFFFF_F000;
      SEG_OFFSET <= 32'h0000_0800 << p;
      PAGING_EN <= p[0];
      @(posedge CLOCK);
      ADDR_VALID <= 1'b0;
      #1;
      `CHK(LIN_VALID, 1'b1)
      `CHK(LIN_PAGED, p[0])
      `CHK(LIN_ADDR, 32'(32'hFFFF_F000 + (32'h0000_0800 << p)))
    end
  endtask

  initial begin
    t_reset();
    t_switch(16'h0028, 32'h0000_0400, 32'h0, 32'h0010_0004, 0, 1'b0);
    t_switch(16'h0030, 32'h0000_0800, 32'h0000_0400, 32'h0020_0008, 12, 1'b1);
    t_switch(16'h0038, 32'h0000_0C00, 32'h0000_0800, 32'h0030_000C, 0, 1'b0);
    t_sys(16'h0038);
    t_fault();
    t_lin();
    print_verdict();
  end
endmodule

bind tsu_top tsu_properties chk (.*);
